// File: rtl/sasms_pkg.sv
// Package for the stop mode selector: parameter word map, field layout,
// reset values, action encodings and timing constants.
// Assumes a single 100 MHz clock in every user of this package.
package sasms_pkg;

   // Parameter word offsets on the parameter port
   localparam logic [11:0] SASMS_ADDR_SVOFF_LIM  = 12'h0001;
   localparam logic [11:0] SASMS_ADDR_BATT       = 12'h0008;
   localparam logic [11:0] SASMS_ADDR_EXT_FORCED_STOP_INPUT  = 12'h000a;
   localparam logic [11:0] SASMS_ADDR_MILD_METH  = 12'h000b;
   localparam logic [11:0] SASMS_ADDR_DECEL_TIME = 12'h030a;
   localparam logic [11:0] SASMS_ADDR_STOP_TRQ   = 12'h0406;

   // Field positions: low nibble 0..3, second nibble 4..7
   localparam int SASMS_LO_NIB = 0;
   localparam int SASMS_HI_NIB = 4;

   // Reset values of each word
   localparam logic [15:0] SASMS_RST_SVOFF_LIM  = 16'h0010;
   localparam logic [15:0] SASMS_RST_BATT       = 16'h0000;
   localparam logic [15:0] SASMS_RST_EXT_FORCED_STOP_INPUT  = 16'h0011;
   localparam logic [15:0] SASMS_RST_MILD_METH  = 16'h0010;
   localparam logic [15:0] SASMS_RST_DECEL_TIME = 16'h0000;
   localparam logic [15:0] SASMS_RST_STOP_TRQ   = 16'h0320;

   // Limits of the two shared numeric settings
   localparam logic [15:0] SASMS_MAX_TRQ  = 16'h0320;
   localparam logic [15:0] SASMS_MAX_TIME = 16'h2710;

   // Timing: one millisecond tick
   localparam int SASMS_CLK_HZ    = 100_000_000;
   localparam int SASMS_MS_CYCLES = SASMS_CLK_HZ / 1000;

   // Servo-off stop field values
   localparam logic [3:0] SASMS_SVOFF_DB_HOLD = 4'h0;
   localparam logic [3:0] SASMS_SVOFF_DB_FREE = 4'h1;
   localparam logic [3:0] SASMS_SVOFF_FREE    = 4'h2;

   // Milder alarm method field values
   localparam logic [3:0] SASMS_MILD_ZERO_SPD = 4'h0;
   localparam logic [3:0] SASMS_MILD_AS_SVOFF = 4'h1;
   localparam logic [3:0] SASMS_MILD_USE_EXT  = 4'h2;

   // Shared five-action encoding (forced stop, extended, limit switch)
   localparam logic [3:0] SASMS_ACT_SVOFF     = 4'h0;
   localparam logic [3:0] SASMS_ACT_TRQ_HOLD  = 4'h1;
   localparam logic [3:0] SASMS_ACT_TRQ_FREE  = 4'h2;
   localparam logic [3:0] SASMS_ACT_TIME_HOLD = 4'h3;
   localparam logic [3:0] SASMS_ACT_TIME_FREE = 4'h4;

   // Resulting drive command
   typedef enum logic [2:0] {
      SASMS_RUN,
      SASMS_DB_STOP,
      SASMS_COAST,
      SASMS_ZERO_SPD,
      SASMS_DECEL_TRQ,
      SASMS_DECEL_TIME
   } sasms_drive_e;

endpackage

// File: rtl/sasms_ms_timer.sv
// Millisecond down-counter for time-based deceleration stops.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module sasms_ms_timer
   import sasms_pkg::*;
#(
   parameter int MS_CYCLES = SASMS_MS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        load,
   input  wire logic [15:0] load_ms,
   input  wire logic        run,
   output var  logic        done
);
   logic [31:0] pre;
   logic [31:0] next_pre;
   logic [15:0] ms_left;
   logic [15:0] next_ms_left;

   // Prescaler gives a one-cycle millisecond enable
   always_comb begin
      next_pre     = pre;
      next_ms_left = ms_left;
      if (load) begin
         next_pre     = '0;
         next_ms_left = load_ms;
      end else if (run && ms_left != 16'h0000) begin
         if (pre == 32'(MS_CYCLES - 1)) begin
            next_pre     = '0;
            next_ms_left = ms_left - 16'h0001;
         end else begin
            next_pre = pre + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre     <= '0;
         ms_left <= '0;
      end else begin
         pre     <= next_pre;
         ms_left <= next_ms_left;
      end
   end

   // Zero time means stop at once
   assign done = (ms_left == 16'h0000) && !load;
endmodule
`default_nettype wire

// File: rtl/sasms_core.sv
// Stop mode selector: holds the parameter words, latches the starred
// stop modes at power-up, and turns stop events into a drive command.
// Assumes event pins are asynchronous and the parameter port is on clk.
//
// Notes on behaviour
// - Servo off/severe alarm: brake-hold, brake-free, free
// - Milder alarm: zero speed, as off, extended
// - Extended mode used only when method equals two
// - Forced stop selects one of five actions
// - Limit switch selects one of five actions
// - One shared stop torque, capped at 800
// - One shared stop time, capped at 10000 ms
// - Low battery: field 0 alarm, 1 warning
// - Starred words act only after power cycle
`timescale 1ns/1ns
`default_nettype none
module sasms_core
   import sasms_pkg::*;
#(
   parameter int MS_CYCLES = SASMS_MS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        prm_wr,
   input  wire logic [11:0] prm_addr,
   input  wire logic [15:0] prm_wdata,
   output var  logic [15:0] prm_rdata,
   input  wire logic        servo_on,
   input  wire logic        severe_alarm_class,
   input  wire logic        milder_alarm_class,
   input  wire logic        forced_stop_input,
   input  wire logic        limit_switch_input,
   input  wire logic        battery_low,
   input  wire logic        motor_stopped,
   output var  sasms_drive_e drive_cmd,
   output var  logic [15:0] stop_torque,
   output var  logic        battery_alarm,
   output var  logic        battery_warning
);
   // Written words (what the host reads back)
   logic [15:0] w_svlim, w_batt, w_extfs, w_mild, w_time, w_trq;
   logic [15:0] next_w_svlim, next_w_batt, next_w_extfs, next_w_mild;
   logic [15:0] next_w_time, next_w_trq;
   // Active starred fields, captured once after reset release
   logic [3:0]  a_svoff, a_lim, a_ext, a_fs, a_mild, a_batt;
   logic        captured;
   // Synchronisers
   logic [5:0]  sync1, sync2;
   logic        ev_sev, ev_mild, ev_fs, ev_lim, ev_svon, ev_batt;

   // Host writes; numeric words clamp to their ranges
   always_comb begin
      next_w_svlim = w_svlim;
      next_w_batt  = w_batt;
      next_w_extfs = w_extfs;
      next_w_mild  = w_mild;
      next_w_time  = w_time;
      next_w_trq   = w_trq;
      if (prm_wr) begin
         case (prm_addr)
            SASMS_ADDR_SVOFF_LIM:  next_w_svlim = prm_wdata;
            SASMS_ADDR_BATT:       next_w_batt  = prm_wdata;
            SASMS_ADDR_EXT_FORCED_STOP_INPUT:  next_w_extfs = prm_wdata;
            SASMS_ADDR_MILD_METH:  next_w_mild  = prm_wdata;
            SASMS_ADDR_DECEL_TIME: next_w_time  = (prm_wdata > SASMS_MAX_TIME)
                                      ? SASMS_MAX_TIME : prm_wdata;
            SASMS_ADDR_STOP_TRQ:   next_w_trq   = (prm_wdata > SASMS_MAX_TRQ)
                                      ? SASMS_MAX_TRQ : prm_wdata;
            default: ;
         endcase
      end
   end

   // Store keeps its words through reset, as the non-volatile parameter
   // memory does, so starred writes survive a restart. Limitation: the
   // host must load it while reset is held at the very first power-up.
   always_ff @(posedge clk) begin
      w_svlim <= next_w_svlim;
      w_batt  <= next_w_batt;
      w_extfs <= next_w_extfs;
      w_mild  <= next_w_mild;
      w_time  <= next_w_time;
      w_trq   <= next_w_trq;
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (prm_addr)
         SASMS_ADDR_SVOFF_LIM:  prm_rdata = w_svlim;
         SASMS_ADDR_BATT:       prm_rdata = w_batt;
         SASMS_ADDR_EXT_FORCED_STOP_INPUT:  prm_rdata = w_extfs;
         SASMS_ADDR_MILD_METH:  prm_rdata = w_mild;
         SASMS_ADDR_DECEL_TIME: prm_rdata = w_time;
         SASMS_ADDR_STOP_TRQ:   prm_rdata = w_trq;
         default:               prm_rdata = 16'h0000;
      endcase
   end

   // Starred fields latch only at the first edge after reset release;
   // power-on reset is the only way a new value becomes active.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         captured <= 1'b0;
         a_svoff  <= SASMS_RST_SVOFF_LIM[3:0];
         a_lim    <= SASMS_RST_SVOFF_LIM[7:4];
         a_ext    <= SASMS_RST_EXT_FORCED_STOP_INPUT[3:0];
         a_fs     <= SASMS_RST_EXT_FORCED_STOP_INPUT[7:4];
         a_mild   <= SASMS_RST_MILD_METH[7:4];
         a_batt   <= SASMS_RST_BATT[3:0];
      end else if (!captured) begin
         captured <= 1'b1;
         a_svoff  <= w_svlim[SASMS_LO_NIB +: 4];
         a_lim    <= w_svlim[SASMS_HI_NIB +: 4];
         a_ext    <= w_extfs[SASMS_LO_NIB +: 4];
         a_fs     <= w_extfs[SASMS_HI_NIB +: 4];
         a_mild   <= w_mild[SASMS_HI_NIB +: 4];
         a_batt   <= w_batt[SASMS_LO_NIB +: 4];
      end
   end

   // Two-flop synchronisers on every event pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {battery_low, servo_on, limit_switch_input,
                   forced_stop_input, milder_alarm_class,
                   severe_alarm_class};
         sync2 <= sync1;
      end
   end
   assign {ev_batt, ev_svon, ev_lim, ev_fs, ev_mild, ev_sev} = sync2;

   // Servo-off stop: brake and hold, brake then coast once stopped, or coast at once
   function automatic sasms_drive_e svoff_cmd(input logic [3:0] f,
                                              input logic       stopped);
      case (f)
         SASMS_SVOFF_DB_HOLD: svoff_cmd = SASMS_DB_STOP;
         SASMS_SVOFF_DB_FREE: svoff_cmd = stopped ? SASMS_COAST
                                                  : SASMS_DB_STOP;
         SASMS_SVOFF_FREE:    svoff_cmd = SASMS_COAST;
         default:             svoff_cmd = SASMS_DB_STOP;
      endcase
   endfunction

   // Priority: severe alarm, servo off, forced stop, milder, limit
   sasms_drive_e cmd;
   logic [3:0]   act;
   logic         use_act;
   logic         lim_hold;
   logic         time_act;
   logic         decel_done;
   always_comb begin
      act      = SASMS_ACT_SVOFF;
      use_act  = 1'b0;
      lim_hold = 1'b0;
      cmd      = SASMS_RUN;
      if (ev_sev || !ev_svon) begin
         cmd = svoff_cmd(a_svoff, motor_stopped);
      end else if (ev_fs) begin
         act     = a_fs;
         use_act = 1'b1;
      end else if (ev_mild) begin
         case (a_mild)
            SASMS_MILD_ZERO_SPD: cmd = SASMS_ZERO_SPD;
            SASMS_MILD_USE_EXT: begin
               act     = a_ext;
               use_act = 1'b1;
            end
            default: cmd = svoff_cmd(a_svoff, motor_stopped);
         endcase
      end else if (ev_lim) begin
         act      = a_lim;
         use_act  = (a_lim <= SASMS_ACT_TIME_FREE);
         lim_hold = 1'b1;
      end
      if (use_act) begin
         case (act)
            SASMS_ACT_SVOFF:
               cmd = svoff_cmd(a_svoff, motor_stopped);
            SASMS_ACT_TRQ_HOLD, SASMS_ACT_TRQ_FREE:
               cmd = !motor_stopped ? SASMS_DECEL_TRQ
                   : (act == SASMS_ACT_TRQ_FREE) ? SASMS_COAST
                   : lim_hold ? SASMS_ZERO_SPD
                   : svoff_cmd(a_svoff, motor_stopped);
            SASMS_ACT_TIME_HOLD, SASMS_ACT_TIME_FREE:
               cmd = !decel_done ? SASMS_DECEL_TIME
                   : (act == SASMS_ACT_TIME_FREE) ? SASMS_COAST
                   : lim_hold ? SASMS_ZERO_SPD
                   : svoff_cmd(a_svoff, motor_stopped);
            default: cmd = SASMS_RUN;
         endcase
      end
   end
   assign time_act = use_act && (act == SASMS_ACT_TIME_HOLD ||
                                 act == SASMS_ACT_TIME_FREE);

   // Restart the ramp timer when a time-based stop begins
   logic time_prev;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         time_prev <= 1'b0;
      end else begin
         time_prev <= time_act;
      end
   end

   sasms_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
      .clk     (clk),
      .rst_b   (rst_b),
      .load    (time_act && !time_prev),
      .load_ms (w_time),
      .run     (time_act),
      .done    (decel_done)
   );

   // Registered outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_cmd       <= SASMS_DB_STOP;
         stop_torque     <= SASMS_RST_STOP_TRQ;
         battery_alarm   <= 1'b0;
         battery_warning <= 1'b0;
      end else begin
         drive_cmd       <= cmd;
         stop_torque     <= w_trq;
         battery_alarm   <= ev_batt && (a_batt == 4'h0);
         battery_warning <= ev_batt && (a_batt == 4'h1);
      end
   end

   // Checks
   battery_sel_a: assert property (@(posedge clk) disable iff (!rst_b)
      ev_batt |=> (battery_alarm == ($past(a_batt) == 4'h0)))
      else $error("battery alarm select wrong");
   battery_excl_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(battery_alarm && battery_warning))
      else $error("alarm and warning together");
   severe_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ev_sev && a_svoff == SASMS_SVOFF_FREE) |=> drive_cmd == SASMS_COAST)
      else $error("severe alarm did not coast");
   mild_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ev_svon && !ev_sev && !ev_fs && ev_mild &&
       a_mild == SASMS_MILD_ZERO_SPD) |=> drive_cmd == SASMS_ZERO_SPD)
      else $error("milder alarm zero speed missing");
   ext_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ev_svon && !ev_sev && !ev_fs && ev_mild &&
       a_mild != SASMS_MILD_USE_EXT) |-> !use_act)
      else $error("extended mode used wrongly");
   fs_trq_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ev_svon && !ev_sev && ev_fs && a_fs == SASMS_ACT_TRQ_FREE &&
       !motor_stopped) |=> drive_cmd == SASMS_DECEL_TRQ)
      else $error("forced stop torque decel missing");
   lim_bad_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ev_svon && !ev_sev && !ev_fs && !ev_mild && ev_lim &&
       a_lim > SASMS_ACT_TIME_FREE) |=> drive_cmd == SASMS_RUN)
      else $error("bad limit code acted");
   trq_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
      stop_torque <= SASMS_MAX_TRQ)
      else $error("stop torque over range");
   time_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
      w_time <= SASMS_MAX_TIME)
      else $error("stop time over range");
   starred_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      $past(captured) |-> $stable(a_fs) && $stable(a_batt))
      else $error("starred field changed live");
   cov_fs_c:   cover property (@(posedge clk) drive_cmd == SASMS_DECEL_TRQ);
   cov_time_c: cover property (@(posedge clk) drive_cmd == SASMS_DECEL_TIME);
   cov_warn_c: cover property (@(posedge clk) battery_warning);
endmodule
`default_nettype wire

// File: sim/sasms_motor_model.sv
// Behavioural motor and drive stage on the far side of the selector.
// Assumes drive_cmd is registered on clk; speed is in arbitrary units.
`timescale 1ns/1ns
`default_nettype none
module sasms_motor_model
   import sasms_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire sasms_drive_e drive_cmd,
   input  wire logic         slow,
   output var  logic         motor_stopped
);
   int speed;
   int step;

   // Slow mode sheds one unit a cycle, so decel phases last a while
   assign step = slow ? 1 : 8;

   // Spins up at once on run, loses speed under any stop command
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         speed <= 0;
      else if (drive_cmd == SASMS_RUN)
         speed <= 40;
      else
         speed <= (speed > step) ? speed - step : 0;
   end

   assign motor_stopped = (speed == 0);
endmodule
`default_nettype wire

// File: sim/servo_alarm_stop_mode_selector_test.sv
// Self-checking bench for the stop mode selector core.
// Assumes the package, the core and the motor model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module servo_alarm_stop_mode_selector_test;
   import sasms_pkg::*;
   logic         clk, rst_b, prm_wr, slow, motor_stopped;
   logic [11:0]  prm_addr;
   logic [15:0]  prm_wdata, prm_rdata, stop_torque;
   logic         servo_on, sev, mil, fs, lim, batt_low, batt_alm, batt_wrn;
   logic [4:0]   ev;
   logic [31:0]  seed;
   sasms_drive_e drive_cmd;
   int           err_count, samples_checked;
   int           word [int];
   int           act [int];

   sasms_core #(.MS_CYCLES(10)) dut_u (
      .clk(clk), .rst_b(rst_b), .prm_wr(prm_wr), .prm_addr(prm_addr),
      .prm_wdata(prm_wdata), .prm_rdata(prm_rdata), .servo_on(servo_on),
      .severe_alarm_class(sev), .milder_alarm_class(mil),
      .forced_stop_input(fs), .limit_switch_input(lim),
      .battery_low(batt_low), .motor_stopped(motor_stopped),
      .drive_cmd(drive_cmd), .stop_torque(stop_torque),
      .battery_alarm(batt_alm), .battery_warning(batt_wrn));

   sasms_motor_model motor_u (
      .clk(clk), .rst_b(rst_b), .drive_cmd(drive_cmd), .slow(slow),
      .motor_stopped(motor_stopped));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic chk(input string what, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Word values at power-up; starred fields latch these
   task automatic model_reset();
      word.delete();
      word[12'h001] = 16'h0010;
      word[12'h008] = 16'h0000;
      word[12'h00a] = 16'h0011;
      word[12'h00b] = 16'h0010;
      word[12'h30a] = 16'h0000;
      word[12'h406] = 16'h0320;
      act = word;
   endtask

   // One-cycle write strobe; model clamps the two live settings
   task automatic wr(input logic [11:0] a, input int v);
      @(posedge clk);
      prm_wr    <= 1'b1;
      prm_addr  <= a;
      prm_wdata <= 16'(v);
      @(posedge clk);
      prm_wr    <= 1'b0;
      if (a == 12'h406 && v > 800) v = 800;
      if (a == 12'h30a && v > 10000) v = 10000;
      if (word.exists(a)) word[a] = v;
   endtask

   task automatic rd_chk(input logic [11:0] a);
      @(posedge clk);
      prm_addr <= a;
      @(negedge clk);
      chk("prm_rdata", prm_rdata, word.exists(a) ? 16'(word[a]) : 16'h0000);
   endtask

   // Result once a servo-off style stop is reached
   function automatic logic [2:0] svoff_res(input int stp);
      int m;
      m = act[12'h001] & 15;
      if (m == 1) return stp ? SASMS_COAST : SASMS_DB_STOP;
      if (m == 2) return SASMS_COAST;
      return SASMS_DB_STOP;
   endfunction

   // Five-action code; lock selects servo lock instead of servo off
   function automatic logic [2:0] act5(input int m, stp, lock);
      logic [2:0] hold;
      logic [2:0] fin;
      hold = lock ? SASMS_ZERO_SPD : svoff_res(stp);
      fin  = (m == 4) ? SASMS_COAST : hold;
      if (m == 0) return svoff_res(stp);
      if (m == 1) return stp ? hold : SASMS_DECEL_TRQ;
      if (m == 2) return stp ? SASMS_COAST : SASMS_DECEL_TRQ;
      if (m == 3 || m == 4)
         return (stp || word[12'h30a] == 0) ? fin : SASMS_DECEL_TIME;
      return SASMS_RUN;
   endfunction

   // Event bits: 0 servo off, 1 severe, 2 milder, 3 forced, 4 limit
   function automatic logic [2:0] pred(input logic [4:0] e, input int stp);
      int mm;
      mm = (act[12'h00b] >> 4) & 15;
      if (e[0] || e[1]) return svoff_res(stp);
      if (e[3]) return act5((act[12'h00a] >> 4) & 15, stp, 0);
      if (e[2] && mm == 0) return SASMS_ZERO_SPD;
      if (e[2] && mm == 2) return act5(act[12'h00a] & 15, stp, 0);
      if (e[2]) return svoff_res(stp);
      if (e[4]) return act5((act[12'h001] >> 4) & 15, stp, 1);
      return SASMS_RUN;
   endfunction

   task automatic wait_stop();
      int n;
      n = 0;
      while (!motor_stopped && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (!motor_stopped) begin
         err_count++;
         stop_test();
      end
   endtask

   task automatic set_ev(input logic [4:0] e);
      @(posedge clk);
      servo_on <= ~e[0];
      sev      <= e[1];
      mil      <= e[2];
      fs       <= e[3];
      lim      <= e[4];
      repeat (4) @(posedge clk);
      #1;
   endtask

   // Factory load of the parameter store, back to back, under reset
   task automatic load_store();
      foreach (word[a]) begin
         @(posedge clk);
         prm_wr    <= 1'b1;
         prm_addr  <= 12'(a);
         prm_wdata <= 16'(word[a]);
      end
      @(posedge clk);
      prm_wr <= 1'b0;
   endtask

   // Host power-cycles the device; starred words become active
   task automatic restart();
      @(posedge clk);
      rst_b <= 1'b0;
      @(negedge clk);
      chk("drive_cmd", 16'(drive_cmd), 16'(SASMS_DB_STOP));
      chk("stop_torque", stop_torque, 16'h0320);
      act = word;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (word[a]) rd_chk(12'(a));
   endtask

   // Random event mixes, speeds and battery levels against the model
   task automatic run_events();
      int bf;
      bf = act[12'h008] & 15;
      repeat (24) begin
         seed = xs(seed);
         ev = seed[4:0];
         @(posedge clk);
         batt_low <= seed[8];
         slow     <= seed[9];
         set_ev(ev);
         chk("drive_cmd", 16'(drive_cmd), 16'(pred(ev, 0)));
         chk("batt_alm", 16'(batt_alm), 16'(seed[8] && bf == 0));
         chk("batt_wrn", 16'(batt_wrn), 16'(seed[8] && bf == 1));
         if (pred(ev, 0) != SASMS_RUN) begin
            wait_stop();
            // Covers the motor run-down and a 2 ms time ramp
            repeat (24) @(posedge clk);
            #1;
            chk("drive_cmd", 16'(drive_cmd), 16'(pred(ev, 1)));
         end
         set_ev(5'h00);
         chk("drive_cmd", 16'(drive_cmd), 16'(SASMS_RUN));
      end
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      prm_wr = 1'b0;
      prm_addr = 12'h000;
      prm_wdata = 16'h0000;
      {sev, mil, fs, lim, batt_low, slow} = 6'h00;
      servo_on = 1'b1;
      err_count = 0;
      samples_checked = 0;
      seed = 32'h94bf;
      model_reset();
      load_store();
      @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("stop_torque", stop_torque, 16'h0320);
      foreach (word[a]) rd_chk(12'(a));
      wr(12'h123, 16'hbeef);
      rd_chk(12'h123);
      // Starred words rewritten live; only readback changes for now
      wr(12'h001, 16'h0042);
      wr(12'h00a, 16'h0044);
      wr(12'h00b, 16'h0000);
      wr(12'h008, 16'h0001);
      foreach (word[a]) rd_chk(12'(a));
      repeat (8) begin
         seed = xs(seed);
         wr(12'h406, int'(seed[9:0]));
         rd_chk(12'h406);
         chk("stop_torque", stop_torque, 16'(word[12'h406]));
         wr(12'h30a, int'(seed[29:16]));
         rd_chk(12'h30a);
      end
      // Defaults still active: starred writes wait for a restart
      run_events();
      // Short ramp so time-based stops end inside the checks
      wr(12'h30a, 2);
      restart();
      // Free stops, time ramps, zero speed and battery warning
      run_events();
      wr(12'h001, 16'h0051);
      wr(12'h00a, 16'h0020);
      wr(12'h00b, 16'h0020);
      wr(12'h008, 16'h0002);
      restart();
      // Brake then coast, bad limit code, extended mode, no battery flag
      run_events();
      stop_test();
   end
endmodule
`default_nettype wire
